// ===== bench/spds_debugger_model.sv
// Debugger model on the one-wire line, with the line's pull-up.
// Assumes the port only ever pulls the line low through pin_oe.
`timescale 1ns/1ps
module spds_debugger_model (
  // Clock and port drive
  input wire logic clk_sys,
  input wire logic pin_oe,
  // Line and high-voltage detector
  output logic pin_in,
  output logic hv_detect
);
  logic drive_low;

  // ==========================================================
  // Line level
  // Pulled up unless one side pulls low
  assign pin_in = ~(drive_low | pin_oe);

  initial
  begin
    drive_low = 1'b0;
    hv_detect = 1'b0;
  end

  // ==========================================================
  // Line actions
  // Low pulse opens enable; a short one is a start bit
  task automatic low_pulse(input int n);
    @(negedge clk_sys);
    drive_low = 1'b1;
    repeat (n) @(negedge clk_sys);
    drive_low = 1'b0;
  endtask

  // Pulse only after power-on reset, then drive low
  task automatic hv_pulse(input int n);
    @(negedge clk_sys);
    hv_detect = 1'b1;
    repeat (n) @(negedge clk_sys);
    hv_detect = 1'b0;
  endtask
endmodule

// ===== bench/test_spds_session.sv
// Self-checking bench for the debug session controller.
// Assumes the debugger model drives the line; events are driven by hand.
`timescale 1ns/1ps
module test_spds_session;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] sel = 2'h0;
  // Events; 14 overflow, 15 direct load and 16 data ready are levels
  logic [16:0] ev = 17'h00000;
  logic [15:0] sync_len = 16'h0000;
  logic [1:0] clk_sel_data = 2'h0;
  logic [2:0] guard_data = 3'h0;
  logic iface_tick = 1'b0;
  logic bit_tick = 1'b0;
  logic [1:0] bcnt = 2'h0;
  logic [7:0] rdy_sh = 8'h00;
  wire logic clk_ready;
  wire logic pin_in;
  wire logic hv_detect;
  wire logic pin_oe, clk_req, sys_reset_req, pin_is_debug, gpio_oe_allow, tx_start;
  wire logic bus_rd_req, instr_accept, port_enabled, error_state, nvm_programming_key;
  wire logic [2:0] error_signature_field;
  wire logic [1:0] interface_clock_control;
  wire logic [2:0] guard_idle_bit_count;
  wire logic [8:0] ob;
  int err_count = 0;
  int tests_run = 0;

  // ==========================================================
  // Clock, ticks and a slow clock-ready answer
  always #2.5 clk_sys = ~clk_sys;
  always @(negedge clk_sys)
  begin
    iface_tick <= ~iface_tick;
    bcnt <= bcnt + 2'h1;
    bit_tick <= (bcnt == 2'h3);
    rdy_sh <= {rdy_sh[6:0], clk_req};
  end
  assign clk_ready = rdy_sh[7];
  assign ob = {gpio_oe_allow, bus_rd_req, instr_accept, sys_reset_req, tx_start,
    error_state, port_enabled, clk_req, pin_oe};

  spds_debugger_model dbg (.clk_sys(clk_sys), .pin_oe(pin_oe), .pin_in(pin_in),
    .hv_detect(hv_detect));

  spds_session #(.GPIO_HOLD_CYC(50), .START_TIMEOUT(16), .ACCESS_TIMEOUT(32)) DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .pin_in(pin_in), .hv_detect(hv_detect),
    .pin_out(), .pin_oe(pin_oe), .reset_pin_function_select(sel),
    .sys_reset_in(ev[13]), .clk_ready(clk_ready), .iface_tick(iface_tick),
    .clk_req(clk_req), .sys_reset_req(sys_reset_req), .pin_is_debug(pin_is_debug),
    .gpio_oe_allow(gpio_oe_allow), .sync_done(ev[0]), .sync_ovf(ev[14]),
    .sync_len(sync_len), .break_det(ev[1]), .parity_err(ev[2]), .frame_err(ev[3]),
    .contention_err(ev[4]), .instr_valid(ev[5]), .instr_is_direct_load(ev[15]),
    .addr_done(ev[6]), .bit_tick(bit_tick), .port_disable_bit(ev[7]),
    .clk_sel_wr(ev[8]), .clk_sel_data(clk_sel_data), .guard_wr(ev[9]),
    .guard_data(guard_data), .key_nvm_in(ev[10]), .sig_read(ev[11]),
    .resp_start(ev[12]), .resp_data_ready(ev[16]), .tx_start(tx_start),
    .bus_rd_req(bus_rd_req), .instr_accept(instr_accept), .port_enabled(port_enabled),
    .error_state(error_state), .error_signature_field(error_signature_field),
    .interface_clock_control(interface_clock_control),
    .guard_idle_bit_count(guard_idle_bit_count),
    .nvm_programming_key(nvm_programming_key));

  // ==========================================================
  // Shared tasks
  task automatic close_out();
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask

  task automatic pulse(input int k);
    ev[k] = 1'b1;
    @(negedge clk_sys);
    ev[k] = 1'b0;
  endtask

  task automatic wait_on(input int k, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && ob[k] !== lvl; i++) @(negedge clk_sys);
    if (ob[k] !== lvl)
    begin
      $display("mismatch wait %0d expected %b seen %b", k, lvl, ob[k]);
      err_count++;
      close_out();
    end
  endtask

  task automatic saw(input int k, input int n, output logic hit);
    hit = 1'b0;
    repeat (n)
    begin
      hit = hit | (ob[k] === 1'b1);
      @(negedge clk_sys);
    end
  endtask

  task automatic enable_port(input logic [15:0] len, input logic ovf);
    repeat (10) @(negedge clk_sys);
    dbg.low_pulse(6);
    wait_on(0, 1'b1, 20);
    check("clk_req_up", clk_req, 1'b1);
    wait_on(0, 1'b0, 30);
    check("line_released", pin_in, 1'b1);
    dbg.low_pulse(2);
    repeat (4) @(negedge clk_sys);
    sync_len = len;
    ev[14] = ovf;
    pulse(0);
    ev[14] = 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_gpio_hold();
    int n;
    sel = 2'h0;
    ev[13] = 1'b1;
    @(negedge clk_sys);
    ev[13] = 1'b0;
    n = 1;
    while (gpio_oe_allow !== 1'b1 && n < 200)
    begin
      @(negedge clk_sys);
      n++;
    end
    check("gpio_hold_long", n >= 50, 1'b1);
    check("gpio_allow", gpio_oe_allow, 1'b1);
    if (gpio_oe_allow !== 1'b1)
      close_out();
  endtask

  task automatic t_timeout();
    dbg.low_pulse(6);
    wait_on(0, 1'b1, 20);
    wait_on(0, 1'b0, 30);
    repeat (20) @(negedge clk_sys);
    check("clk_req_early", clk_req, 1'b1);
    wait_on(1, 1'b0, 40);
    check("off_timeout", port_enabled, 1'b0);
  endtask

  task automatic t_bad_sync();
    enable_port(16'h0008, 1'b0);
    wait_on(1, 1'b0, 6);
    check("off_short", port_enabled, 1'b0);
    enable_port(16'hffff, 1'b1);
    wait_on(1, 1'b0, 6);
    check("off_long", port_enabled, 1'b0);
  endtask

  task automatic t_enable();
    logic hit;
    enable_port(16'h0040, 1'b0);
    wait_on(2, 1'b1, 10);
    pulse(5);
    saw(6, 3, hit);
    check("first_instr", hit, 1'b1);
    ev[15] = 1'b1;
    pulse(5);
    ev[15] = 1'b0;
    saw(7, 4, hit);
    check("rd_before_addr", hit, 1'b0);
    pulse(6);
    saw(7, 3, hit);
    check("rd_after_addr", hit, 1'b1);
  endtask

  task automatic t_errors();
    spds_pkg::spds_sig_e codes [3];
    logic hit;
    int i;
    codes[0] = spds_pkg::SPDS_SIG_PARITY;
    codes[1] = spds_pkg::SPDS_SIG_FRAME;
    codes[2] = spds_pkg::SPDS_SIG_CONTENTION;
    for (i = 0; i < 3; i++)
    begin
      clk_sel_data = 2'h1;
      pulse(8);
      repeat (2) @(negedge clk_sys);
      check("clk_sel_set", interface_clock_control, 2'h1);
      pulse(2 + i);
      wait_on(3, 1'b1, 5);
      check("sig", error_signature_field, codes[i]);
      pulse(5);
      saw(6, 4, hit);
      check("err_ignore", hit, 1'b0);
      pulse(1);
      wait_on(3, 1'b0, 5);
      check("brk_clk_sel", interface_clock_control, spds_pkg::CLKSEL_DEFAULT);
      check("brk_sig_kept", error_signature_field, codes[i]);
      check("brk_active", port_enabled, 1'b1);
      pulse(11);
      repeat (2) @(negedge clk_sys);
      check("sig_clear", error_signature_field, spds_pkg::SPDS_SIG_NONE);
    end
  endtask

  task automatic t_guard();
    int n;
    int i;
    guard_data = 3'h3;
    pulse(9);
    repeat (2) @(negedge clk_sys);
    check("guard_set", guard_idle_bit_count, 3'h3);
    ev[16] = 1'b1;
    pulse(12);
    n = 0;
    i = 0;
    while (tx_start !== 1'b1 && i < 80)
    begin
      @(negedge clk_sys);
      if (bit_tick === 1'b1)
        n++;
      i++;
    end
    check("tx_seen", tx_start, 1'b1);
    check("guard_bits", n >= 3 && n <= 4, 1'b1);
    ev[16] = 1'b0;
    if (tx_start !== 1'b1)
      close_out();
  endtask

  task automatic t_access_to();
    logic hit;
    pulse(12);
    saw(4, 40, hit);
    check("no_tx_waiting", hit | error_state, 1'b0);
    wait_on(3, 1'b1, 60);
    check("sig_to", error_signature_field, spds_pkg::SPDS_SIG_ACCESS_TO);
    pulse(1);
    wait_on(3, 1'b0, 5);
  endtask

  task automatic t_disable();
    logic hit;
    pulse(10);
    pulse(9);
    clk_sel_data = 2'h2;
    pulse(8);
    repeat (2) @(negedge clk_sys);
    check("key_held", nvm_programming_key, 1'b1);
    pulse(7);
    saw(5, 3, hit);
    check("sys_reset_req", hit, 1'b1);
    check("dis_clk_req", clk_req, 1'b0);
    check("dis_key", nvm_programming_key, 1'b0);
    check("dis_guard", guard_idle_bit_count, spds_pkg::GUARD_RESET);
    check("dis_sig", error_signature_field, spds_pkg::SPDS_SIG_NONE);
    check("dis_clk_sel", interface_clock_control, spds_pkg::CLKSEL_DEFAULT);
    check("dis_off", port_enabled, 1'b0);
  endtask

  task automatic t_hv();
    sel = 2'h0;
    pulse(13);
    repeat (3) @(negedge clk_sys);
    check("pin_gpio", pin_is_debug, 1'b0);
    dbg.hv_pulse(20000);
    check("pin_debug", pin_is_debug, 1'b1);
    repeat (10) @(negedge clk_sys);
    check("hv_hold", pin_oe | port_enabled, 1'b0);
    enable_port(16'h0040, 1'b0);
    wait_on(2, 1'b1, 10);
    pulse(10);
    pulse(7);
    repeat (3) @(negedge clk_sys);
    check("hv_pin_kept", pin_is_debug, 1'b1);
    arst_n = 1'b0;
    repeat (12) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("por_pin", pin_is_debug, 1'b0);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (12) @(negedge clk_sys);
    arst_n = 1'b1;
    @(negedge clk_sys);
    check("rst_clk_req", clk_req, 1'b0);
    check("rst_pin_oe", pin_oe, 1'b0);
    check("rst_enabled", port_enabled, 1'b0);
    check("rst_clk_sel", interface_clock_control, spds_pkg::CLKSEL_DEFAULT);
    check("rst_guard", guard_idle_bit_count, spds_pkg::GUARD_RESET);
    t_gpio_hold();
    sel = 2'h1;
    t_timeout();
    t_bad_sync();
    t_enable();
    t_errors();
    t_guard();
    t_access_to();
    t_disable();
    t_hv();
    close_out();
  end
endmodule

// ===== core/spds_session.sv
// Session control for a single pin debug port: enable, self disable, errors, guard time.
// Assumes baud measurement, frame shifting and bus access are done by neighbouring logic.
//
// Function
// - First instruction accepted without extra sync
// - High voltage pulse forces pin to debug
// - Pulse edge resets port; low pin resumes
// - Only power-on reset ends high voltage mode
// - GPIO driver off 8.8ms after system reset; 32-bit GPIO_HOLD_CYC works out to 42014 cycles, about 210 us
// - Self disable after 65536 ticks without sync
// - Self disable on too long/short sync
// - Self disable drops all power requests
// - Disable write: system reset, clear settings
// - Detect errors, record signature
// - Error state ignores everything except break
// - Guard idle bits before first response
// - Guard is minimum; time-out bounds wait
// - Two guard bits recommended, debugger one
// - Each instruction is one synced byte
// - Direct load waits for its address
// - Sync 0x55 sets the baud rate
// - Break resets state, clock select default
// - Hold line low until clock stable
`timescale 1ns/1ps
module spds_session #(
  parameter int unsigned GPIO_HOLD_CYC = spds_pkg::GPIO_HOLD_CYC,
  parameter int unsigned START_TIMEOUT = spds_pkg::START_TIMEOUT_TICKS,
  parameter int unsigned ACCESS_TIMEOUT = spds_pkg::ACCESS_TIMEOUT_TICKS,
  parameter int unsigned SYNC_MIN = spds_pkg::SYNC_MIN_LEN,
  parameter int unsigned SYNC_LEN_W = 16
) (
  // Clock and power-on reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Pin side, asynchronous
  input wire logic pin_in,
  input wire logic hv_detect,
  output logic pin_out,
  output logic pin_oe,
  // Configuration and system
  input wire logic [1:0] reset_pin_function_select,
  input wire logic sys_reset_in,
  input wire logic clk_ready,
  input wire logic iface_tick,
  output logic clk_req,
  output logic sys_reset_req,
  output logic pin_is_debug,
  output logic gpio_oe_allow,
  // Frame layer events
  input wire logic sync_done,
  input wire logic sync_ovf,
  input wire logic [SYNC_LEN_W-1:0] sync_len,
  input wire logic break_det,
  input wire logic parity_err,
  input wire logic frame_err,
  input wire logic contention_err,
  input wire logic instr_valid,
  input wire logic instr_is_direct_load,
  input wire logic addr_done,
  input wire logic bit_tick,
  // Control space writes and reads
  input wire logic port_disable_bit,
  input wire logic clk_sel_wr,
  input wire logic [1:0] clk_sel_data,
  input wire logic guard_wr,
  input wire logic [2:0] guard_data,
  input wire logic key_nvm_in,
  input wire logic sig_read,
  // Response path
  input wire logic resp_start,
  input wire logic resp_data_ready,
  output logic tx_start,
  output logic bus_rd_req,
  output logic instr_accept,
  // Status
  output logic port_enabled,
  output logic error_state,
  output logic [2:0] error_signature_field,
  output logic [1:0] interface_clock_control,
  output logic [2:0] guard_idle_bit_count,
  output logic nvm_programming_key
);

  localparam int GW = $clog2(GPIO_HOLD_CYC + 1);
  localparam int TW = $clog2(START_TIMEOUT + 1);
  localparam int AW = $clog2(ACCESS_TIMEOUT + 1);

  typedef struct packed {
    spds_pkg::spds_state_e state;
    logic hv_latch;
    logic hv_prev;
    logic pin_prev;
    logic sync_started;
    logic [TW-1:0] to_cnt;
    logic [GW-1:0] gpio_cnt;
    logic gpio_allow;
    logic clk_req;
    logic pin_oe;
    logic pin_debug;
    logic sys_rst_req;
    logic [2:0] err_sig;
    logic [1:0] clk_sel;
    logic [2:0] guard;
    logic key_ok;
    logic instr_acc;
    logic resp_pend;
    logic [2:0] guard_cnt;
    logic [AW-1:0] wait_cnt;
    logic tx_start;
    logic load_pend;
    logic bus_rd;
    logic live;
    logic err;
  } spds_regs_s;

  spds_regs_s q_r;
  spds_regs_s q_nxt;
  logic [1:0] pins_s;
  logic pin_s;
  logic hv_s;

  // ==========================================================
  // Pin synchronisers
  spds_sync2 #(.W(2)) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .async_in({hv_detect, pin_in}),
    .sync_out(pins_s)
  );
  assign pin_s = pins_s[0];
  assign hv_s = pins_s[1];

  function automatic logic is_live(input spds_pkg::spds_state_e s);
    is_live = (s == spds_pkg::SPDS_ACTIVE) || (s == spds_pkg::SPDS_ERROR);
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    logic pin_fall;
    logic sync_bad;
    pin_fall = q_r.pin_prev && !pin_s;
    sync_bad = sync_ovf || (sync_len < SYNC_LEN_W'(SYNC_MIN));
    q_nxt = q_r;
    q_nxt.hv_prev = hv_s;
    q_nxt.pin_prev = pin_s;
    q_nxt.sys_rst_req = 1'b0;
    q_nxt.instr_acc = 1'b0;
    q_nxt.tx_start = 1'b0;
    q_nxt.bus_rd = 1'b0;
    // GPIO output hold-off after every system reset
    if (sys_reset_in)
      q_nxt.gpio_cnt = GW'(GPIO_HOLD_CYC);
    else if (q_r.gpio_cnt != '0)
      q_nxt.gpio_cnt = q_r.gpio_cnt - GW'(1);
    q_nxt.gpio_allow = (reset_pin_function_select != spds_pkg::PINSEL_GPIO) ||
      (q_nxt.gpio_cnt == '0);
    if (sig_read)
      q_nxt.err_sig = spds_pkg::SPDS_SIG_NONE;
    unique case (q_r.state)
      spds_pkg::SPDS_OFF:
      begin
        if (q_r.pin_debug && pin_fall)
        begin
          q_nxt.state = spds_pkg::SPDS_DRIVE_LOW;
          q_nxt.clk_req = 1'b1;
          q_nxt.pin_oe = 1'b1;
        end
      end
      spds_pkg::SPDS_HV_HOLD:
      begin
        if (!hv_s && !pin_s)
        begin
          q_nxt.state = spds_pkg::SPDS_DRIVE_LOW;
          q_nxt.clk_req = 1'b1;
          q_nxt.pin_oe = 1'b1;
        end
      end
      spds_pkg::SPDS_DRIVE_LOW:
      begin
        if (clk_ready)
        begin
          q_nxt.state = spds_pkg::SPDS_WAIT_SYNC;
          q_nxt.pin_oe = 1'b0;
          q_nxt.to_cnt = '0;
          q_nxt.sync_started = 1'b0;
        end
      end
      spds_pkg::SPDS_WAIT_SYNC:
      begin
        if (pin_fall)
          q_nxt.sync_started = 1'b1;
        else if (!q_r.sync_started && iface_tick)
          q_nxt.to_cnt = q_r.to_cnt + TW'(1);
        if (sync_done && sync_bad)
        begin
          q_nxt.state = spds_pkg::SPDS_OFF;
          q_nxt.clk_req = 1'b0;
        end
        else if (sync_done)
          q_nxt.state = spds_pkg::SPDS_ACTIVE;
        else if (!q_r.sync_started && iface_tick && q_r.to_cnt == TW'(START_TIMEOUT - 1))
        begin
          q_nxt.state = spds_pkg::SPDS_OFF;
          q_nxt.clk_req = 1'b0;
        end
      end
      spds_pkg::SPDS_ACTIVE:
      begin
        if (port_disable_bit)
        begin
          q_nxt.state = spds_pkg::SPDS_OFF;
          q_nxt.sys_rst_req = 1'b1;
          q_nxt.clk_req = 1'b0;
          q_nxt.clk_sel = spds_pkg::CLKSEL_DEFAULT;
          q_nxt.guard = spds_pkg::GUARD_RESET;
          q_nxt.key_ok = 1'b0;
          q_nxt.err_sig = spds_pkg::SPDS_SIG_NONE;
          q_nxt.resp_pend = 1'b0;
          q_nxt.load_pend = 1'b0;
        end
        else if (!break_det)
        begin
          if (parity_err || frame_err || contention_err ||
            (q_r.resp_pend && q_r.wait_cnt == AW'(ACCESS_TIMEOUT)))
          begin
            q_nxt.state = spds_pkg::SPDS_ERROR;
            q_nxt.resp_pend = 1'b0;
            q_nxt.load_pend = 1'b0;
            if (parity_err)
              q_nxt.err_sig = spds_pkg::SPDS_SIG_PARITY;
            else if (frame_err)
              q_nxt.err_sig = spds_pkg::SPDS_SIG_FRAME;
            else if (contention_err)
              q_nxt.err_sig = spds_pkg::SPDS_SIG_CONTENTION;
            else
              q_nxt.err_sig = spds_pkg::SPDS_SIG_ACCESS_TO;
          end
          else
          begin
            if (instr_valid)
            begin
              q_nxt.instr_acc = 1'b1;
              q_nxt.load_pend = q_r.load_pend || instr_is_direct_load;
            end
            if (q_r.load_pend && addr_done)
            begin
              q_nxt.bus_rd = 1'b1;
              q_nxt.load_pend = 1'b0;
            end
            if (clk_sel_wr)
              q_nxt.clk_sel = clk_sel_data;
            if (guard_wr)
              q_nxt.guard = guard_data;
            if (key_nvm_in)
              q_nxt.key_ok = 1'b1;
            if (resp_start)
            begin
              q_nxt.resp_pend = 1'b1;
              q_nxt.guard_cnt = q_r.guard;
              q_nxt.wait_cnt = '0;
            end
            else if (q_r.resp_pend)
            begin
              if (bit_tick && q_r.guard_cnt != 3'h0)
                q_nxt.guard_cnt = q_r.guard_cnt - 3'h1;
              if (iface_tick)
                q_nxt.wait_cnt = q_r.wait_cnt + AW'(1);
              if (q_r.guard_cnt == 3'h0 && resp_data_ready)
              begin
                q_nxt.tx_start = 1'b1;
                q_nxt.resp_pend = 1'b0;
              end
            end
          end
        end
      end
      spds_pkg::SPDS_ERROR:
      begin
        q_nxt.state = spds_pkg::SPDS_ERROR;
      end
      default:
      begin
        q_nxt.state = spds_pkg::SPDS_OFF;
        q_nxt.clk_req = 1'b0;
        q_nxt.pin_oe = 1'b0;
      end
    endcase
    // Break recovers a live session to defaults, keeping the signature
    if (is_live(q_r.state) && break_det && !port_disable_bit)
    begin
      q_nxt.state = spds_pkg::SPDS_ACTIVE;
      q_nxt.clk_sel = spds_pkg::CLKSEL_DEFAULT;
      q_nxt.guard = spds_pkg::GUARD_RESET;
      q_nxt.resp_pend = 1'b0;
      q_nxt.load_pend = 1'b0;
      q_nxt.instr_acc = 1'b0;
    end
    // Rising high voltage edge resets the port and latches the pin function
    if (hv_s && !q_r.hv_prev)
    begin
      q_nxt.state = spds_pkg::SPDS_HV_HOLD;
      q_nxt.hv_latch = 1'b1;
      q_nxt.clk_req = 1'b0;
      q_nxt.pin_oe = 1'b0;
      q_nxt.key_ok = 1'b0;
      q_nxt.clk_sel = spds_pkg::CLKSEL_DEFAULT;
      q_nxt.guard = spds_pkg::GUARD_RESET;
      q_nxt.resp_pend = 1'b0;
      q_nxt.load_pend = 1'b0;
      q_nxt.instr_acc = 1'b0;
      q_nxt.tx_start = 1'b0;
      q_nxt.bus_rd = 1'b0;
    end
    q_nxt.pin_debug = q_nxt.hv_latch ||
      (reset_pin_function_select == spds_pkg::PINSEL_DEBUG);
    // Status decoded ahead so the outputs leave a flop
    q_nxt.live = is_live(q_nxt.state);
    q_nxt.err = (q_nxt.state == spds_pkg::SPDS_ERROR);
    if (sig_read && q_nxt.err_sig == spds_pkg::SPDS_SIG_NONE && q_r.state == q_nxt.state)
      q_nxt.err_sig = spds_pkg::SPDS_SIG_NONE;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q_r <= '0;
      q_r.state <= spds_pkg::SPDS_OFF;
      q_r.pin_prev <= 1'b0;
      q_r.gpio_cnt <= GW'(GPIO_HOLD_CYC);
      q_r.clk_sel <= spds_pkg::CLKSEL_DEFAULT;
      q_r.guard <= spds_pkg::GUARD_RESET;
    end
    else
      q_r <= q_nxt;
  end

  // ==========================================================
  // Outputs
  assign pin_out = 1'b0;
  assign pin_oe = q_r.pin_oe;
  assign clk_req = q_r.clk_req;
  assign sys_reset_req = q_r.sys_rst_req;
  assign pin_is_debug = q_r.pin_debug;
  assign gpio_oe_allow = q_r.gpio_allow;
  assign tx_start = q_r.tx_start;
  assign bus_rd_req = q_r.bus_rd;
  assign instr_accept = q_r.instr_acc;
  assign port_enabled = q_r.live;
  assign error_state = q_r.err;
  assign error_signature_field = q_r.err_sig;
  assign interface_clock_control = q_r.clk_sel;
  assign guard_idle_bit_count = q_r.guard;
  assign nvm_programming_key = q_r.key_ok;

  // ==========================================================
  // Checks
  property p_hv_sticky;
    @(posedge clk_sys) disable iff (!arst_n)
    q_r.hv_latch |=> q_r.hv_latch && q_r.pin_debug;
  endproperty
  a_hv_sticky: assert property (p_hv_sticky) else $error("hv pin function lost");

  property p_drive_low;
    @(posedge clk_sys) disable iff (!arst_n)
    (q_r.state == spds_pkg::SPDS_DRIVE_LOW) == (q_r.pin_oe && q_r.clk_req);
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("line drive mismatch");

  property p_timeout;
    @(posedge clk_sys) disable iff (!arst_n)
    (q_r.state == spds_pkg::SPDS_WAIT_SYNC) && !q_r.sync_started && iface_tick &&
      !sync_done && !hv_s && (q_r.to_cnt == TW'(START_TIMEOUT - 1))
      |=> (q_r.state == spds_pkg::SPDS_OFF) && !q_r.clk_req;
  endproperty
  a_timeout: assert property (p_timeout) else $error("start timeout missed");

  property p_bad_sync;
    @(posedge clk_sys) disable iff (!arst_n)
    (q_r.state == spds_pkg::SPDS_WAIT_SYNC) && sync_done && !hv_s &&
      (sync_ovf || (sync_len < SYNC_LEN_W'(SYNC_MIN)))
      |=> (q_r.state == spds_pkg::SPDS_OFF) && !q_r.clk_req;
  endproperty
  a_bad_sync: assert property (p_bad_sync) else $error("bad sync kept port on");

  property p_good_sync;
    @(posedge clk_sys) disable iff (!arst_n)
    (q_r.state == spds_pkg::SPDS_WAIT_SYNC) && sync_done && !sync_ovf &&
      (sync_len >= SYNC_LEN_W'(SYNC_MIN)) && !hv_s |=> port_enabled;
  endproperty
  a_good_sync: assert property (p_good_sync) else $error("good sync not enabled");

  property p_disable;
    @(posedge clk_sys) disable iff (!arst_n)
    (q_r.state == spds_pkg::SPDS_ACTIVE) && port_disable_bit && !hv_s
      |=> sys_reset_req && !clk_req && !nvm_programming_key &&
      (interface_clock_control == spds_pkg::CLKSEL_DEFAULT) ##1 !sys_reset_req;
  endproperty
  a_disable: assert property (p_disable) else $error("disable write incomplete");

  property p_err_enter;
    @(posedge clk_sys) disable iff (!arst_n)
    (q_r.state == spds_pkg::SPDS_ACTIVE) && parity_err && !port_disable_bit &&
      !break_det && !hv_s |=> error_state &&
      (error_signature_field == spds_pkg::SPDS_SIG_PARITY);
  endproperty
  a_err_enter: assert property (p_err_enter) else $error("parity not recorded");

  property p_err_ignore;
    @(posedge clk_sys) disable iff (!arst_n)
    error_state && !break_det |=> !instr_accept && !tx_start && !bus_rd_req;
  endproperty
  a_err_ignore: assert property (p_err_ignore) else $error("error state answered");

  property p_break;
    @(posedge clk_sys) disable iff (!arst_n)
    port_enabled && break_det && !port_disable_bit && !hv_s
      |=> (interface_clock_control == spds_pkg::CLKSEL_DEFAULT) && !error_state;
  endproperty
  a_break: assert property (p_break) else $error("break did not reset");

  property p_gpio;
    @(posedge clk_sys) disable iff (!arst_n)
    sys_reset_in && (reset_pin_function_select == spds_pkg::PINSEL_GPIO)
      |=> !gpio_oe_allow;
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio driver enabled early");

  property p_guard;
    @(posedge clk_sys) disable iff (!arst_n)
    tx_start |-> $past(q_r.guard_cnt) == 3'h0 && $past(q_r.resp_pend);
  endproperty
  a_guard: assert property (p_guard) else $error("tx before guard bits");

endmodule

// ===== core/spds_sync2.sv
// Two flop synchroniser for asynchronous pin levels.
// Assumes inputs arrive from outside the clk_sys domain.
`timescale 1ns/1ps
module spds_sync2 #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ===== include/spds_pkg.sv
// Constants and types for the single pin debug session controller.
// Assumes a 200 MHz system clock; all users refer to names by package scope.
package spds_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned GPIO_HOLD_US = 8800;
  localparam int unsigned GPIO_HOLD_CYC = (GPIO_HOLD_US * 1000000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int unsigned START_TIMEOUT_TICKS = 65536;
  localparam int unsigned ACCESS_TIMEOUT_TICKS = 65536;
  localparam int unsigned SYNC_MIN_LEN = 16;

  // ==========================================================
  // Reset pin function select encodings
  localparam logic [1:0] PINSEL_GPIO = 2'h0;
  localparam logic [1:0] PINSEL_DEBUG = 2'h1;

  // ==========================================================
  // Interface clock selection
  localparam logic [1:0] CLKSEL_DEFAULT = 2'h3;

  // ==========================================================
  // Guard idle bit count reset value
  localparam logic [2:0] GUARD_RESET = 3'h0;

  // ==========================================================
  // Session states, Gray along off, drive low, wait sync, active, error
  typedef enum logic [2:0] {
    SPDS_OFF = 3'b000,
    SPDS_DRIVE_LOW = 3'b001,
    SPDS_WAIT_SYNC = 3'b011,
    SPDS_ACTIVE = 3'b010,
    SPDS_ERROR = 3'b110,
    SPDS_HV_HOLD = 3'b100
  } spds_state_e;

  // ==========================================================
  // Error signature field codes
  typedef enum logic [2:0] {
    SPDS_SIG_NONE = 3'h0,
    SPDS_SIG_PARITY = 3'h1,
    SPDS_SIG_FRAME = 3'h2,
    SPDS_SIG_ACCESS_TO = 3'h3,
    SPDS_SIG_CONTENTION = 3'h4
  } spds_sig_e;

endpackage
